// [verilog/ictc_ctrl.sv]
// Purpose: per-instruction cycle count and bus cycle typing
// Assumes: decode presents descriptor with next instr sources
// Notes: bus types are registered, one cycle behind acceptance
`timescale 1ns/1ps
module ictc_ctrl (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    input wire ictc_pkg::ictc_instr_t in_instr,
    output logic in_ready,
    output ictc_pkg::ictc_cyc_t ibus_cyc,
    output ictc_pkg::ictc_cyc_t dbus_cyc,
    output logic busy,
    output logic last_cyc
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    ictc_pkg::ictc_state_t state;
    ictc_pkg::ictc_state_t next_state;
    logic [ictc_pkg::CW-1:0] cnt;
    logic [ictc_pkg::CW-1:0] next_cnt;
    ictc_pkg::ictc_plan_t plan;
    ictc_pkg::ictc_plan_t next_plan;
    ictc_pkg::ictc_plan_t new_plan;
    ictc_pkg::ictc_cyc_t next_ibus;
    ictc_pkg::ictc_cyc_t next_dbus;
    logic next_busy;
    logic next_last;
    logic hazard;
    logic accept;
    logic [ictc_pkg::CW-1:0] n;

    // ---------------------------------------------------------------
    // hazard and plan
    // ---------------------------------------------------------------
    // next instruction reads the loaded register
    always_comb begin
        hazard = (in_instr.nxt_use_a &&
                  in_instr.nxt_src_a == in_instr.dest) ||
                 (in_instr.nxt_use_b &&
                  in_instr.nxt_src_b == in_instr.dest);
    end

    // internal count, refill and data accesses per class
    always_comb begin
        n = ictc_pkg::CW'(in_instr.nregs);
        new_plan = '0;
        case (in_instr.cls)
            ictc_pkg::ICTC_DATA_OP: begin
                if (in_instr.pc_dest) begin
                    new_plan.refill = 1'b1;
                    if (in_instr.logical || in_instr.op_shift) begin
                        new_plan.k = ictc_pkg::CW'(
                            ictc_pkg::DP_LOGIC_PC_K);
                    end else begin
                        new_plan.k = ictc_pkg::CW'(
                            ictc_pkg::DP_ARITH_PC_K);
                    end
                end else if (in_instr.reg_shift) begin
                    new_plan.k = ictc_pkg::CW'(
                        ictc_pkg::DP_SHIFT_K);
                end else begin
                    new_plan.k = '0;
                end
            end
            ictc_pkg::ICTC_SINGLE_LOAD_INSTR: begin
                new_plan.m = 6'h01;
                if (in_instr.pc_dest) begin
                    new_plan.refill = 1'b1;
                    new_plan.k = in_instr.scaled ?
                        ictc_pkg::CW'(ictc_pkg::LD_PC_SCALED_K) :
                        ictc_pkg::CW'(ictc_pkg::LD_PC_K);
                end else begin
                    new_plan.k = '0;
                    if (in_instr.shift_off) begin
                        new_plan.k = ictc_pkg::CW'(
                            ictc_pkg::LD_SHOFF_K);
                    end
                    if (hazard && in_instr.sub_word) begin
                        new_plan.k = new_plan.k + ictc_pkg::CW'(
                            ictc_pkg::LD_SUB_IL_K);
                    end else if (hazard) begin
                        new_plan.k = new_plan.k + ictc_pkg::CW'(
                            ictc_pkg::LD_WORD_IL_K);
                    end
                end
            end
            ictc_pkg::ICTC_DOUBLE_LOAD_INSTR: begin
                new_plan.m = ictc_pkg::CW'(ictc_pkg::LDD_WORDS);
                new_plan.k = ictc_pkg::CW'(ictc_pkg::LDD_K) +
                    ictc_pkg::CW'(hazard);
            end
            ictc_pkg::ICTC_MULTI_LOAD_INSTR: begin
                new_plan.m = n;
                if (in_instr.pc_dest) begin
                    new_plan.refill = 1'b1;
                    new_plan.k = n + ictc_pkg::CW'(
                        ictc_pkg::LDM_PC_EXTRA_K);
                end else if (n == 6'h01) begin
                    new_plan.fseq = 1'b1;
                    new_plan.k = ictc_pkg::CW'(
                        ictc_pkg::SINGLE_K);
                end else begin
                    new_plan.k = n - 6'h01 +
                        ictc_pkg::CW'(hazard);
                end
            end
            ictc_pkg::ICTC_MULTI_STORE_INSTR: begin
                new_plan.m = n;
                if (n == 6'h01) begin
                    new_plan.k = ictc_pkg::CW'(
                        ictc_pkg::SINGLE_K);
                end else begin
                    new_plan.k = n - 6'h01;
                end
            end
            default: begin
                new_plan = '0;
            end
        endcase
        new_plan.last = new_plan.k + (new_plan.refill ?
            ictc_pkg::CW'(ictc_pkg::REFILL_CYC) : 6'h00);
    end

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    // ready while idle or on the final cycle, so back to back works
    always_comb begin
        in_ready = (state == ictc_pkg::ICTC_IDLE) ||
                   (cnt == plan.last);
        accept = in_valid && in_ready;
    end

    // next state, counter and held plan
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_plan = plan;
        case (state)
            ictc_pkg::ICTC_IDLE: begin
                if (accept) begin
                    next_state = ictc_pkg::ICTC_RUN;
                    next_cnt = ictc_pkg::CNT_RST;
                    next_plan = new_plan;
                end
            end
            ictc_pkg::ICTC_RUN: begin
                if (accept) begin
                    next_cnt = ictc_pkg::CNT_RST;
                    next_plan = new_plan;
                end else if (cnt == plan.last) begin
                    next_state = ictc_pkg::ICTC_IDLE;
                    next_cnt = ictc_pkg::CNT_RST;
                    next_plan = '0;
                end else begin
                    next_cnt = cnt + 6'h01;
                end
            end
            default: begin
                next_state = ictc_pkg::ICTC_IDLE;
                next_cnt = ictc_pkg::CNT_RST;
                next_plan = '0;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // cycle typing
    // ---------------------------------------------------------------
    // fetch S, then k internal, then N and S refetch on pc write;
    // data: N then S per access (all S when fseq), internal for the rest
    always_comb begin
        next_ibus = ictc_pkg::ICTC_CYC_I;
        next_dbus = ictc_pkg::ICTC_CYC_I;
        next_busy = (next_state == ictc_pkg::ICTC_RUN);
        next_last = next_busy && (next_cnt == next_plan.last);
        if (next_busy) begin
            if (next_cnt == 6'h00) begin
                next_ibus = ictc_pkg::ICTC_CYC_S;
            end else if (next_cnt <= next_plan.k) begin
                next_ibus = ictc_pkg::ICTC_CYC_I;
            end else if (next_cnt == next_plan.k + 6'h01) begin
                next_ibus = ictc_pkg::ICTC_CYC_N;
            end else begin
                next_ibus = ictc_pkg::ICTC_CYC_S;
            end
            if (next_cnt < next_plan.m) begin
                if (next_cnt == 6'h00 && !next_plan.fseq) begin
                    next_dbus = ictc_pkg::ICTC_CYC_N;
                end else begin
                    next_dbus = ictc_pkg::ICTC_CYC_S;
                end
            end
        end
    end

    // register state and outputs
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= ictc_pkg::ICTC_IDLE;
            cnt <= ictc_pkg::CNT_RST;
            plan <= '0;
            ibus_cyc <= ictc_pkg::ICTC_CYC_I;
            dbus_cyc <= ictc_pkg::ICTC_CYC_I;
            busy <= 1'b0;
            last_cyc <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            plan <= next_plan;
            ibus_cyc <= next_ibus;
            dbus_cyc <= next_dbus;
            busy <= next_busy;
            last_cyc <= next_last;
        end
    end

endmodule

// [verilog/ictc_pkg.sv]
// Purpose: shared types and counts for the cycle timing control
// Assumes: one core clock, decode supplies one descriptor per instr
// Notes: cycle type codes are this block's own encoding
package ictc_pkg;

    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int CW = 6;  // cycle counter width
    localparam int NW = 5;  // register count width, 1..16
    localparam int RW = 4;  // register number width

    // ---------------------------------------------------------------
    // internal cycle, data access and refetch counts per instruction class
    // ---------------------------------------------------------------
    localparam int DP_SHIFT_K = 1;  // register shift, no pc write
    localparam int DP_ARITH_PC_K = 0;  // arithmetic op writing pc
    localparam int DP_LOGIC_PC_K = 1;  // logical or shifted op to pc
    localparam int LD_SHOFF_K = 1;  // shifted offset extra cycle
    localparam int LD_WORD_IL_K = 1;  // word load-use interlock
    localparam int LD_SUB_IL_K = 2;  // byte/half/unaligned interlock
    localparam int LD_PC_K = 2;  // word load into pc
    localparam int LD_PC_SCALED_K = 3;  // pc load, scaled offset
    localparam int LDD_K = 1;  // doubleword load base
    localparam int LDD_WORDS = 2;  // doubleword data accesses
    localparam int LDM_PC_EXTRA_K = 1;  // pc multi-load: n+1 internal
    localparam int SINGLE_K = 1;  // one-register multi transfer
    localparam int REFILL_CYC = 2;  // nonseq + seq refetch after pc

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [CW-1:0] CNT_RST = 6'h00;

    // ---------------------------------------------------------------
    // enumerations
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ICTC_CYC_N = 2'h0,  // nonsequential
        ICTC_CYC_S = 2'h1,  // sequential
        ICTC_CYC_I = 2'h2,  // internal
        ICTC_CYC_C = 2'h3   // coprocessor register transfer
    } ictc_cyc_t;

    typedef enum logic [2:0] {
        ICTC_DATA_OP = 3'h0,
        ICTC_SINGLE_LOAD_INSTR = 3'h1,
        ICTC_DOUBLE_LOAD_INSTR = 3'h2,
        ICTC_MULTI_LOAD_INSTR = 3'h3,
        ICTC_MULTI_STORE_INSTR = 3'h4
    } ictc_cls_t;

    typedef enum logic [1:0] {
        ICTC_IDLE = 2'b01,
        ICTC_RUN = 2'b10
    } ictc_state_t;

    // ---------------------------------------------------------------
    // carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        ictc_cls_t cls;
        logic pc_dest;     // pc written (or in list)
        logic reg_shift;   // shift amount from a register
        logic op_shift;    // operand shifted
        logic logical;     // logical data output
        logic shift_off;   // shifted address offset
        logic scaled;      // scaled register offset
        logic sub_word;    // byte, halfword or unaligned word
        logic [NW-1:0] nregs;   // registers moved
        logic [RW-1:0] dest;    // last loaded register
        logic nxt_use_a;        // next instr reads src a
        logic [RW-1:0] nxt_src_a;
        logic nxt_use_b;        // next instr reads src b
        logic [RW-1:0] nxt_src_b;
    } ictc_instr_t;

    typedef struct packed {
        logic [CW-1:0] k;     // internal cycles on instruction bus
        logic refill;         // nonseq + seq refetch at end
        logic [CW-1:0] m;     // data memory accesses
        logic fseq;           // first data access sequential
        logic [CW-1:0] last;  // final cycle index
    } ictc_plan_t;

endpackage

// [tb/ictc_mem_model.sv]
// Purpose: memory side tally of bus cycle types per instruction
// Assumes: types registered, busy and last_cyc frame each instr
// Notes: tally = {cycles, iS, iN, dS, dN, coproc}, 6 bits each
`timescale 1ns/1ps
module ictc_mem_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic busy,
    input wire logic last_cyc,
    input wire ictc_pkg::ictc_cyc_t ibus_cyc,
    input wire ictc_pkg::ictc_cyc_t dbus_cyc,
    output logic done,
    output logic [35:0] tally
);
    // ---------------------------------------------------------------
    // counting
    // ---------------------------------------------------------------
    logic [35:0] acc;
    logic [35:0] cur;
    // add this cycle to the running counts
    always_comb begin
        cur = acc;
        cur[35:30] = acc[35:30] + 6'h01;
        if (ibus_cyc == ictc_pkg::ICTC_CYC_S) cur[29:24] = acc[29:24] + 6'h01;
        if (ibus_cyc == ictc_pkg::ICTC_CYC_N) cur[23:18] = acc[23:18] + 6'h01;
        if (dbus_cyc == ictc_pkg::ICTC_CYC_S) cur[17:12] = acc[17:12] + 6'h01;
        if (dbus_cyc == ictc_pkg::ICTC_CYC_N) cur[11:6] = acc[11:6] + 6'h01;
        if (ibus_cyc == ictc_pkg::ICTC_CYC_C || dbus_cyc == ictc_pkg::ICTC_CYC_C)
            cur[5:0] = acc[5:0] + 6'h01;
    end
    // close the tally on the final cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            acc <= '0;
            done <= 1'b0;
            tally <= '0;
        end else begin
            done <= busy && last_cyc;
            if (busy && last_cyc) begin
                tally <= cur;
                acc <= '0;
            end else if (busy) begin
                acc <= cur;
            end
        end
    end
endmodule

// [tb/ictc_ctrl_chk.sv]
// Purpose: port level timing checks of the cycle controller
// Assumes: single clock, synchronous active high reset
// Notes: bound into every ictc_ctrl instance
`timescale 1ns/1ps
module ictc_ctrl_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    input wire ictc_pkg::ictc_instr_t in_instr,
    input wire logic in_ready,
    input wire ictc_pkg::ictc_cyc_t ibus_cyc,
    input wire ictc_pkg::ictc_cyc_t dbus_cyc,
    input wire logic busy,
    input wire logic last_cyc
);
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic take;
    logic dop;
    logic ld;
    // acceptance and class decode
    assign take = in_valid && in_ready;
    assign dop = in_instr.cls == ictc_pkg::ICTC_DATA_OP;
    assign ld = in_instr.cls == ictc_pkg::ICTC_SINGLE_LOAD_INSTR;
    a_idle_bus:
    assert property (!busy |-> ibus_cyc == ictc_pkg::ICTC_CYC_I
        && dbus_cyc == ictc_pkg::ICTC_CYC_I) else $error("idle not internal");
    a_no_coproc:
    assert property (ibus_cyc != ictc_pkg::ICTC_CYC_C
        && dbus_cyc != ictc_pkg::ICTC_CYC_C) else $error("coproc cycle");
    a_take_fetch:
    assert property (take |=> busy && ibus_cyc == ictc_pkg::ICTC_CYC_S)
        else $error("no sequential fetch after accept");
    a_ready_hold:
    assert property (busy && !last_cyc |-> !in_ready)
        else $error("ready before last cycle");
    a_ready_last:
    assert property (last_cyc || !busy |-> in_ready)
        else $error("not ready at last or idle");
    a_last_idle:
    assert property (last_cyc && !take |=> !busy && !last_cyc)
        else $error("busy after last cycle");
    a_simple_one:
    assert property (take && dop && !in_instr.pc_dest && !in_instr.reg_shift
        |=> last_cyc && dbus_cyc == ictc_pkg::ICTC_CYC_I)
        else $error("simple data op not one cycle");
    a_shift_two:
    assert property (take && dop && !in_instr.pc_dest && in_instr.reg_shift
        |=> !last_cyc ##1 last_cyc) else $error("register shift not two");
    a_arith_pc:
    assert property (take && dop && in_instr.pc_dest && !in_instr.logical
        && !in_instr.op_shift && !in_instr.reg_shift
        |=> ##1 ibus_cyc == ictc_pkg::ICTC_CYC_N ##1 last_cyc)
        else $error("arith pc write order");
    a_plain_load:
    assert property (take && ld && !in_instr.pc_dest && !in_instr.shift_off
        && !in_instr.nxt_use_a && !in_instr.nxt_use_b
        |=> last_cyc && dbus_cyc == ictc_pkg::ICTC_CYC_N)
        else $error("plain load not one cycle");
    a_load_stall:
    assert property (take && ld && !in_instr.pc_dest && !in_instr.shift_off
        && !in_instr.sub_word && in_instr.nxt_use_a
        && in_instr.nxt_src_a == in_instr.dest
        |=> !last_cyc && dbus_cyc == ictc_pkg::ICTC_CYC_N
        ##1 last_cyc && dbus_cyc == ictc_pkg::ICTC_CYC_I)
        else $error("load-use stall missing");
endmodule
bind ictc_ctrl ictc_ctrl_chk chk (.clock(clock), .rst(rst),
    .in_valid(in_valid), .in_instr(in_instr), .in_ready(in_ready),
    .ibus_cyc(ibus_cyc), .dbus_cyc(dbus_cyc), .busy(busy),
    .last_cyc(last_cyc));

// [tb/tb_top.sv]
// Purpose: random and corner instruction streams against cycle tables
// Assumes: descriptors held until accepted, back to back allowed
// Notes: expected tallies come from exp_of, one per instruction
`timescale 1ns/1ps
module tb_top;
    // ---------------------------------------------------------------
    // bench
    // ---------------------------------------------------------------
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic in_valid = 1'b0;
    ictc_pkg::ictc_instr_t in_instr = '0;
    logic in_ready, busy, last_cyc, done;
    ictc_pkg::ictc_cyc_t ibus_cyc, dbus_cyc;
    logic [35:0] tally;
    logic [31:0] seed = 32'h48cbc1aa;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    ictc_pkg::ictc_instr_t pend[$];
    // free running clock
    always #5 clock = ~clock;
    ictc_ctrl dut (.clock(clock), .rst(rst), .in_valid(in_valid),
        .in_instr(in_instr), .in_ready(in_ready), .ibus_cyc(ibus_cyc),
        .dbus_cyc(dbus_cyc), .busy(busy), .last_cyc(last_cyc));
    ictc_mem_model mem (.clock(clock), .rst(rst), .busy(busy),
        .last_cyc(last_cyc), .ibus_cyc(ibus_cyc), .dbus_cyc(dbus_cyc),
        .done(done), .tally(tally));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // cycles and bus tallies per descriptor
    function automatic logic [35:0] exp_of(input ictc_pkg::ictc_instr_t d);
        int l, is, in, ds, dn, n;
        logic u;
        n = d.nregs;
        u = (d.nxt_use_a && d.nxt_src_a == d.dest)
            || (d.nxt_use_b && d.nxt_src_b == d.dest);
        is = 1;
        in = 0;
        ds = 0;
        dn = 0;
        // double loads and stores never refetch on a pc flag
        if (d.pc_dest && d.cls != ictc_pkg::ICTC_DOUBLE_LOAD_INSTR
                && d.cls != ictc_pkg::ICTC_MULTI_STORE_INSTR) begin
            is = 2;
            in = 1;
        end
        case (d.cls)
        ictc_pkg::ICTC_DATA_OP: l = d.pc_dest ? (d.logical || d.op_shift
            ? 4 : 3) : (d.reg_shift ? 2 : 1);
        ictc_pkg::ICTC_SINGLE_LOAD_INSTR: begin
            dn = 1;
            l = d.pc_dest ? (d.scaled ? 6 : 5) : 1 + d.shift_off
                + (u ? (d.sub_word ? 2 : 1) : 0);
        end
        ictc_pkg::ICTC_DOUBLE_LOAD_INSTR: begin
            l = 2 + u;
            dn = 1;
            ds = 1;
        end
        ictc_pkg::ICTC_MULTI_LOAD_INSTR: begin
            dn = (n > 1 || d.pc_dest) ? 1 : 0;
            ds = n - dn;
            l = d.pc_dest ? n + 4 : (n == 1 ? 2 : n + u);
        end
        default: begin
            l = n == 1 ? 2 : n;
            dn = 1;
            ds = n - 1;
        end
        endcase
        return {6'(l), 6'(is), 6'(in), 6'(ds), 6'(dn), 6'h00};
    endfunction
    task automatic chk(input logic [35:0] got, input logic [35:0] want);
        total_checks++;
        if (got !== want) begin
            failures++;
            $display("CHECK FAILED %0t: tally %h want %h", $time, got, want);
        end
    endtask
    task test_done;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic send(input ictc_pkg::ictc_instr_t d);
        in_instr <= d;
        in_valid <= 1'b1;
        @(negedge clock);
        while (in_ready !== 1'b1) @(negedge clock);
        @(posedge clock);
        pend.push_back(d);
    endtask
    // compare each finished instruction
    always @(negedge clock) begin
        if (done === 1'b1) begin
            if (pend.size() == 0) chk(tally, 36'h0);
            else begin
                in_instr_t_chk(pend.pop_front());
            end
        end
    end
    task automatic in_instr_t_chk(input ictc_pkg::ictc_instr_t d);
        case (d.cls)
        ictc_pkg::ICTC_DATA_OP: begin
            chk(tally, exp_of(d));
        end
        ictc_pkg::ICTC_SINGLE_LOAD_INSTR: begin
            chk(tally, exp_of(d));
        end
        ictc_pkg::ICTC_DOUBLE_LOAD_INSTR: begin
            chk(tally, exp_of(d));
        end
        ictc_pkg::ICTC_MULTI_LOAD_INSTR: begin
            chk(tally, exp_of(d));
        end
        default: begin
            chk(tally, exp_of(d));
        end
        endcase
    endtask
    // hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            $display("CHECK FAILED %0t: timeout", $time);
            test_done();
        end
    end
    initial begin
        ictc_pkg::ictc_instr_t d;
        logic [31:0] r;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        d = '0;
        d.cls = ictc_pkg::ICTC_SINGLE_LOAD_INSTR;
        d.shift_off = 1'b1;
        d.sub_word = 1'b1;
        d.nxt_use_b = 1'b1;
        send(d);
        d = '0;
        d.cls = ictc_pkg::ICTC_SINGLE_LOAD_INSTR;
        d.pc_dest = 1'b1;
        d.scaled = 1'b1;
        send(d);
        d = '0;
        d.cls = ictc_pkg::ICTC_MULTI_LOAD_INSTR;
        d.pc_dest = 1'b1;
        d.nregs = 5'h10;
        send(d);
        d.pc_dest = 1'b0;
        d.nregs = 5'h01;
        send(d);
        d.cls = ictc_pkg::ICTC_MULTI_STORE_INSTR;
        send(d);
        $display("test corner done");
        repeat (300) begin
            r = rnd();
            d = r[28:0];
            r = rnd();
            d.cls = ictc_pkg::ictc_cls_t'(3'(r % 32'd5));
            d.nregs = 5'(1 + r[11:8]);
            if (r[31]) d.nxt_src_a = d.dest;
            if (d.cls == ictc_pkg::ICTC_DATA_OP && d.pc_dest) begin
                d.reg_shift = 1'b0;
            end
            if (d.cls == ictc_pkg::ICTC_MULTI_LOAD_INSTR
                    && d.nregs == 5'h01) begin
                d.nxt_use_a = 1'b0;
                d.nxt_use_b = 1'b0;
            end
            if (r[30] && r[29]) begin
                in_valid <= 1'b0;
                @(posedge clock);
            end
            send(d);
        end
        in_valid <= 1'b0;
        repeat (40) if (pend.size() != 0) @(negedge clock);
        if (pend.size() != 0) chk(36'h1, 36'h0);
        $display("test random done");
        test_done();
    end
endmodule
